// file: common/ubf_pkg.sv
// Package for the serial port baud, FIFO and interrupt block.
// Assumes a single 10 MHz system clock and a byte-wide register port.
package ubf_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER  = 3'h1;
    localparam logic [2:0] OFS_IIR  = 3'h2;
    localparam logic [2:0] OFS_LCR  = 3'h3;
    localparam logic [2:0] OFS_LSR  = 3'h5;
    localparam logic [2:0] OFS_SCR  = 3'h7;

    // ==========================================================
    // Field positions
    localparam int LCR_STOP_BIT  = 2;
    localparam int LCR_PAR_BIT   = 3;
    localparam int LCR_DIVISOR_ACCESS_BIT_BIT  = 7;
    localparam int IER_RDA_BIT   = 0;
    localparam int IER_THR_BIT   = 1;
    localparam int IER_RLS_BIT   = 2;
    localparam int FCR_EN_BIT    = 0;
    localparam int FCR_RXRST_BIT = 1;
    localparam int FCR_TXRST_BIT = 2;
    localparam int DIV_HS_BIT    = 15;
    localparam logic [7:0] IER_MASK = 8'h0f;

    // ==========================================================
    // Interrupt identification codes
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_RLS  = 4'h6;
    localparam logic [3:0] IIR_RDA  = 4'h4;
    localparam logic [3:0] IIR_CTO  = 4'hc;
    localparam logic [3:0] IIR_HOLDING_EMPTY_FLAG = 4'h2;
    localparam logic [1:0] IIR_FIFO_ON = 2'h3;

    // ==========================================================
    // Sizes and timing
    localparam int         PTR_W         = 4;
    localparam int         CNT_W         = 5;
    localparam logic [4:0] FIFO_DEPTH    = 5'h10;
    localparam logic [4:0] HOLD_DEPTH    = 5'h01;
    localparam logic [4:0] TRIG_ONE      = 5'h01;
    localparam logic [15:0] DIV_ZERO_EFF = 16'h0003;
    localparam logic [3:0] CHAR_BASE_BITS = 4'h7;
    localparam logic [11:0] TICKS_PER_BIT = 12'h010;
    localparam logic [11:0] TO_CHARS      = 12'h004;

    // ==========================================================
    // Types
    typedef struct packed {
        logic       brk;
        logic       frm;
        logic       par;
        logic [7:0] data;
    } ubf_rx_char_s;

    typedef enum logic [2:0] {
        TXS_BUSY  = 3'b001,
        TXS_DELAY = 3'b010,
        TXS_EMPTY = 3'b100
    } ubf_txs_e;

endpackage

// file: rtl/ubf_uart_core.sv
// Baud generator, FIFOs, interrupt identification and polled status.
// Serial engine sits beside it on SYS_CLK; REF_OSC is an outside pin.
`timescale 1ns/10ps

module ubf_uart_core (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST,
    input  wire logic [2:0]            REG_ADDR,
    input  wire logic [7:0]            REG_WDATA,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    output logic      [7:0]            REG_RDATA,
    input  wire logic                  REF_OSC,
    input  wire logic                  HIGH_SPEED,
    input  wire logic [4:0]            TRIG_LEVEL,
    input  wire logic                  RX_PUSH,
    input  wire ubf_pkg::ubf_rx_char_s RX_CHAR,
    input  wire logic                  TX_POP,
    input  wire logic                  TX_SHIFT_EMPTY,
    output logic                       TX_VALID,
    output logic      [7:0]            TX_DATA,
    output logic                       BAUD_16X,
    output logic                       BAUD_TICK,
    output logic      [7:0]            LINE_CTRL,
    output logic                       INTR
);
    import ubf_pkg::*;

    // ==========================================================
    // Decode helpers
    function automatic logic at(input logic [2:0] a, input logic [2:0] o);
        at = (a == o);
    endfunction

    function automatic logic [15:0] div_effective(input logic [15:0] d,
                                                  input logic        hs);
        logic [15:0] v;
        v = (hs && d[DIV_HS_BIT]) ? {1'b0, d[14:0]} : d;
        div_effective = (v == 16'h0) ? DIV_ZERO_EFF : v;
    endfunction

    logic [7:0]  ier_r, lcr_r, scr_r, dll_r, dlh_r, rdata_r;
    logic        fen_r;
    logic        ref_s1_r, ref_s2_r, ref_s3_r;
    logic [15:0] cnt_r;
    logic        baud_r, baud_q_r, intr_r;

    wire divisor_access_bit   = lcr_r[LCR_DIVISOR_ACCESS_BIT_BIT];
    wire wr_dll = REG_WR && at(REG_ADDR, OFS_DATA) && divisor_access_bit;
    wire wr_dlh = REG_WR && at(REG_ADDR, OFS_IER) && divisor_access_bit;
    wire wr_thr = REG_WR && at(REG_ADDR, OFS_DATA) && !divisor_access_bit;
    wire wr_ier = REG_WR && at(REG_ADDR, OFS_IER) && !divisor_access_bit;
    wire wr_fcr = REG_WR && at(REG_ADDR, OFS_IIR);
    wire wr_lcr = REG_WR && at(REG_ADDR, OFS_LCR);
    wire wr_scr = REG_WR && at(REG_ADDR, OFS_SCR);
    wire rd_rbr = REG_RD && at(REG_ADDR, OFS_DATA) && !divisor_access_bit;
    wire rd_iir = REG_RD && at(REG_ADDR, OFS_IIR);
    wire rd_lsr = REG_RD && at(REG_ADDR, OFS_LSR);
    wire fen_chg = wr_fcr && (REG_WDATA[FCR_EN_BIT] != fen_r);

    // ==========================================================
    // Control registers
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ier_r <= 8'h00;
            lcr_r <= 8'h00;
            scr_r <= 8'h00;
            dll_r <= 8'h00;
            dlh_r <= 8'h00;
            fen_r <= 1'b0;
        end else begin
            if (wr_ier) ier_r <= REG_WDATA & IER_MASK;
            if (wr_lcr) lcr_r <= REG_WDATA;
            if (wr_scr) scr_r <= REG_WDATA;
            if (wr_dll) dll_r <= REG_WDATA;
            if (wr_dlh) dlh_r <= REG_WDATA;
            if (wr_fcr) fen_r <= REG_WDATA[FCR_EN_BIT];
        end
    end

    // ==========================================================
    // Baud generator
    // Reference pin synchronised; edge seen between stages 2 and 3
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_s3_r <= 1'b0;
        end else begin
            ref_s1_r <= REF_OSC;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
        end
    end

    wire        ref_rise = ref_s2_r && !ref_s3_r;
    wire [15:0] div_nxt  = {wr_dlh ? REG_WDATA : dlh_r,
                            wr_dll ? REG_WDATA : dll_r};
    wire [15:0] div_e    = div_effective({dlh_r, dll_r}, HIGH_SPEED);
    wire        div_two  = (div_e == 16'h2);
    wire        div_one  = (div_e == 16'h1);
    wire        div_low  = div_two ? (cnt_r == 16'h2)
                         : (cnt_r == div_e) || (cnt_r == div_e - 16'h1);

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cnt_r <= DIV_ZERO_EFF;
        end else if (wr_dll || wr_dlh) begin
            cnt_r <= div_effective(div_nxt, HIGH_SPEED);
        end else if (ref_rise) begin
            cnt_r <= (cnt_r <= 16'h1) ? div_e : cnt_r - 16'h1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            baud_r   <= 1'b1;
            baud_q_r <= 1'b1;
        end else begin
            baud_r   <= div_one ? !ref_s2_r : !div_low;
            baud_q_r <= baud_r;
        end
    end

    // One tick per 16x period drives all character timing
    wire tick16 = baud_r && !baud_q_r;
    assign BAUD_16X  = baud_r;
    assign BAUD_TICK = tick16;
    assign LINE_CTRL = lcr_r;

    // ==========================================================
    // Character time in 16x ticks
    wire [3:0]  char_bits  = CHAR_BASE_BITS + {2'b00, lcr_r[1:0]}
                           + {3'b000, lcr_r[LCR_PAR_BIT]}
                           + {3'b000, lcr_r[LCR_STOP_BIT]};
    wire [11:0] char_ticks = {8'h00, char_bits} * TICKS_PER_BIT;
    wire [11:0] to_limit   = char_ticks * TO_CHARS;
    wire [11:0] tx_dly     = char_ticks - TICKS_PER_BIT;

    // ==========================================================
    // Receive FIFO
    ubf_rx_char_s     rx_mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0] rx_wp_r, rx_rp_r;
    logic [CNT_W-1:0] rx_cnt_r;
    logic [FIFO_DEPTH-1:0] rx_err_v;

    wire [CNT_W-1:0] cap     = fen_r ? FIFO_DEPTH : HOLD_DEPTH;
    wire rx_empty  = (rx_cnt_r == '0);
    wire rx_full   = (rx_cnt_r >= cap);
    wire rx_push   = RX_PUSH && !rx_full;
    wire overrun   = RX_PUSH && rx_full;
    wire rx_pop    = rd_rbr && !rx_empty;
    wire rx_clr    = fen_chg || (wr_fcr && REG_WDATA[FCR_RXRST_BIT]);
    ubf_rx_char_s rx_top;
    assign rx_top  = rx_mem_r[rx_rp_r];

    genvar gi;
    generate
        for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_rx
            wire [PTR_W-1:0] off = PTR_W'(gi) - rx_rp_r;
            assign rx_err_v[gi] = ({1'b0, off} < rx_cnt_r)
                && (rx_mem_r[gi].brk || rx_mem_r[gi].frm || rx_mem_r[gi].par);
            always_ff @(posedge SYS_CLK) begin
                if (rx_push && rx_wp_r == PTR_W'(gi)) rx_mem_r[gi] <= RX_CHAR;
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK) begin
        if (RST || rx_clr) begin
            rx_wp_r  <= '0;
            rx_rp_r  <= '0;
            rx_cnt_r <= '0;
        end else begin
            rx_wp_r  <= rx_wp_r + PTR_W'(rx_push);
            rx_rp_r  <= rx_rp_r + PTR_W'(rx_pop);
            rx_cnt_r <= rx_cnt_r + CNT_W'(rx_push) - CNT_W'(rx_pop);
        end
    end

    // ==========================================================
    // Transmit FIFO
    logic [7:0]       tx_mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0] tx_wp_r, tx_rp_r;
    logic [CNT_W-1:0] tx_cnt_r;

    wire tx_empty = (tx_cnt_r == '0);
    wire tx_push  = wr_thr && (tx_cnt_r < cap);
    wire tx_pop   = TX_POP && !tx_empty;
    wire tx_clr   = fen_chg || (wr_fcr && REG_WDATA[FCR_TXRST_BIT]);

    generate
        for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_tx
            always_ff @(posedge SYS_CLK) begin
                if (tx_push && tx_wp_r == PTR_W'(gi)) tx_mem_r[gi] <= REG_WDATA;
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK) begin
        if (RST || tx_clr) begin
            tx_wp_r  <= '0;
            tx_rp_r  <= '0;
            tx_cnt_r <= '0;
        end else begin
            tx_wp_r  <= tx_wp_r + PTR_W'(tx_push);
            tx_rp_r  <= tx_rp_r + PTR_W'(tx_pop);
            tx_cnt_r <= tx_cnt_r + CNT_W'(tx_push) - CNT_W'(tx_pop);
        end
    end

    assign TX_VALID = !tx_empty;
    assign TX_DATA  = tx_mem_r[tx_rp_r];

    // ==========================================================
    // Transmit empty indication
    ubf_txs_e    txs_r, txs_nxt;
    logic [11:0] dly_r;
    logic        two_seen_r, holding_empty_flag_pend_r;

    always_comb begin
        txs_nxt = txs_r;
        case (txs_r)
            TXS_BUSY:  if (tx_empty && !tx_push) txs_nxt = two_seen_r ?
                           TXS_EMPTY : TXS_DELAY;
            TXS_DELAY: if (!tx_empty || tx_push) txs_nxt = TXS_BUSY;
                       else if (dly_r == 12'h0) txs_nxt = TXS_EMPTY;
            TXS_EMPTY: if (!tx_empty || tx_push) txs_nxt = TXS_BUSY;
            default:   txs_nxt = TXS_EMPTY;
        endcase
        if (tx_clr) txs_nxt = TXS_EMPTY;
    end

    wire enter_empty = (txs_nxt == TXS_EMPTY) && (txs_r != TXS_EMPTY);
    wire holding_empty_flag        = (txs_r == TXS_EMPTY);

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            txs_r      <= TXS_EMPTY;
            dly_r      <= 12'h0;
            two_seen_r <= 1'b0;
        end else begin
            txs_r <= txs_nxt;
            if (txs_nxt == TXS_DELAY && txs_r != TXS_DELAY) dly_r <= tx_dly;
            else if (tick16 && dly_r != 12'h0) dly_r <= dly_r - 12'h1;
            if (enter_empty) two_seen_r <= 1'b0;
            else if (tx_cnt_r >= 5'h02) two_seen_r <= 1'b1;
        end
    end

    // ==========================================================
    // Line status
    logic oe_r;
    always_ff @(posedge SYS_CLK) begin
        if (RST) oe_r <= 1'b0;
        else oe_r <= overrun || (oe_r && !rd_lsr);
    end

    wire [2:0] top_err = rx_empty ? 3'b000
                       : {rx_top.brk, rx_top.frm, rx_top.par};
    wire [7:0] line_status_reg = {fen_r && (|rx_err_v), holding_empty_flag && TX_SHIFT_EMPTY, holding_empty_flag,
                      top_err, oe_r, !rx_empty};

    // ==========================================================
    // Receive timeout
    logic [11:0] to_cnt_r;
    wire to_hit  = (to_cnt_r >= to_limit);
    wire to_pend = to_hit && fen_r && ier_r[IER_RDA_BIT] && !rx_empty;

    always_ff @(posedge SYS_CLK) begin
        if (RST || rx_empty || rx_pop || (rx_push && !to_pend)) begin
            to_cnt_r <= 12'h0;
        end else if (tick16 && !to_hit) begin
            to_cnt_r <= to_cnt_r + 12'h1;
        end
    end

    // ==========================================================
    // Interrupt identification
    wire [CNT_W-1:0] trig = (fen_r && TRIG_LEVEL != '0) ? TRIG_LEVEL
                                                        : TRIG_ONE;
    wire rls_act  = ier_r[IER_RLS_BIT] && (oe_r || (|top_err));
    wire rda_act  = ier_r[IER_RDA_BIT] && (rx_cnt_r >= trig);
    wire holding_empty_flag_act = ier_r[IER_THR_BIT] && holding_empty_flag_pend_r;
    wire [3:0] iir_id = rls_act  ? IIR_RLS
                      : rda_act  ? IIR_RDA
                      : to_pend  ? IIR_CTO
                      : holding_empty_flag_act ? IIR_HOLDING_EMPTY_FLAG
                      : IIR_NONE;
    wire [7:0] interrupt_ident_reg = {fen_r ? IIR_FIFO_ON : 2'b00, 2'b00, iir_id};

    always_ff @(posedge SYS_CLK) begin
        if (RST) holding_empty_flag_pend_r <= 1'b0;
        else holding_empty_flag_pend_r <= enter_empty || fen_chg
            || (holding_empty_flag_pend_r && !wr_thr && !(rd_iir && iir_id == IIR_HOLDING_EMPTY_FLAG));
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) intr_r <= 1'b0;
        else intr_r <= (iir_id != IIR_NONE);
    end
    assign INTR = intr_r;

    // ==========================================================
    // Read port
    logic [7:0] rd_val;
    always_comb begin
        case (REG_ADDR)
            OFS_DATA: rd_val = divisor_access_bit ? dll_r : rx_top.data;
            OFS_IER:  rd_val = divisor_access_bit ? dlh_r : ier_r;
            OFS_IIR:  rd_val = interrupt_ident_reg;
            OFS_LCR:  rd_val = lcr_r;
            OFS_LSR:  rd_val = line_status_reg;
            OFS_SCR:  rd_val = scr_r;
            default:  rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) rdata_r <= 8'h00;
        else rdata_r <= REG_RD ? rd_val : 8'h00;
    end
    assign REG_RDATA = rdata_r;

    // ==========================================================
    // Assertions
    sequence s_scr_write;
        REG_WR && at(REG_ADDR, OFS_SCR);
    endsequence
    sequence s_scr_read;
        REG_RD && at(REG_ADDR, OFS_SCR);
    endsequence

    a_scratch_readback: assert property (@(posedge SYS_CLK) disable iff (RST)
        s_scr_write ##1 s_scr_read |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("scratch byte did not read back");
    a_div_reload: assert property (@(posedge SYS_CLK) disable iff (RST)
        (wr_dll || wr_dlh) |=> cnt_r == div_e)
        else $error("divisor write did not reload counter");
    a_div_zero_three: assert property (@(posedge SYS_CLK) disable iff (RST)
        (!HIGH_SPEED && {dlh_r, dll_r} == 16'h0) |-> div_e == 16'h3)
        else $error("divisor zero not treated as three");
    a_div_one_inverse: assert property (@(posedge SYS_CLK) disable iff (RST)
        div_one && $stable(div_e) |=> baud_r == !$past(ref_s2_r))
        else $error("divisor one output not inverse of reference");
    a_low_two_counts: assert property (@(posedge SYS_CLK) disable iff (RST)
        (div_e > 16'h2) && cnt_r == div_e && !wr_dll && !wr_dlh
        |=> !baud_r)
        else $error("output not low in first count");
    a_line_prio: assert property (@(posedge SYS_CLK) disable iff (RST)
        rls_act |-> interrupt_ident_reg[3:0] == IIR_RLS)
        else $error("line status not highest priority");
    a_rda_trigger: assert property (@(posedge SYS_CLK) disable iff (RST)
        !rls_act && ier_r[IER_RDA_BIT] && rx_cnt_r >= trig
        |-> iir_id == IIR_RDA)
        else $error("data available id missing at trigger");
    a_ready_on_push: assert property (@(posedge SYS_CLK) disable iff (RST)
        rx_push && !rx_clr |=> line_status_reg[0])
        else $error("data ready not set after push");
    a_timeout_clear: assert property (@(posedge SYS_CLK) disable iff (RST)
        to_pend && rx_pop |=> !to_pend && to_cnt_r == 12'h0)
        else $error("timeout not cleared by read");
    a_polled_quiet: assert property (@(posedge SYS_CLK) disable iff (RST)
        !ier_r[IER_RDA_BIT] |-> !to_pend && iir_id != IIR_RDA)
        else $error("receive event reported in polled mode");
    a_holding_empty_flag_write: assert property (@(posedge SYS_CLK) disable iff (RST)
        wr_thr && !fen_chg |=> !holding_empty_flag_pend_r)
        else $error("holding write did not clear holding-empty");
endmodule

// file: verification/ubf_far_model.sv
// Far-side model: reference oscillator and serial engine strobes.
// Assumes the core's SYS_CLK; receive pushes are started by the bench.
`timescale 1ns/10ps
module ubf_far_model (
    input  wire logic             SYS_CLK,
    input  wire logic             STALL,
    input  wire logic             TX_VALID,
    input  wire logic [7:0]       TX_DATA,
    output logic                  REF_OSC = 1'b0,
    output logic                  RX_PUSH = 1'b0,
    output ubf_pkg::ubf_rx_char_s RX_CHAR = '0,
    output logic                  TX_POP = 1'b0,
    output logic                  TX_SHIFT_EMPTY = 1'b1,
    output logic      [7:0]       LAST_BYTE = 8'h00
);
    import ubf_pkg::*;
    logic [2:0] ref_cnt = 3'h0;
    logic [5:0] shift_cnt = 6'h00;
    // ==========================================
    // Free-running reference, ten clocks a period
    always @(posedge SYS_CLK) begin
        ref_cnt <= (ref_cnt == 3'h4) ? 3'h0 : ref_cnt + 3'h1;
        if (ref_cnt == 3'h4) begin
            REF_OSC <= ~REF_OSC;
        end
    end
    // Takes one byte, then shifts it out for 63 clocks
    always @(posedge SYS_CLK) begin
        TX_POP <= TX_VALID && !STALL && !TX_POP && TX_SHIFT_EMPTY;
        TX_SHIFT_EMPTY <= !TX_POP && shift_cnt <= 6'h01;
        if (TX_POP) begin
            LAST_BYTE <= TX_DATA;
            shift_cnt <= 6'h3f;
        end else if (shift_cnt != 6'h00) begin
            shift_cnt <= shift_cnt - 6'h01;
        end
    end
    // Idle value changes so stale data is never seen
    task automatic send(input ubf_rx_char_s c);
        @(posedge SYS_CLK);
        RX_PUSH <= 1'b1;
        RX_CHAR <= c;
        @(posedge SYS_CLK);
        RX_PUSH <= 1'b0;
        RX_CHAR <= ~c;
    endtask
endmodule

// file: verification/test_uart_baud_fifo_interrupts.sv
// Self-checking bench for the baud, FIFO and interrupt core.
// Assumes ubf_far_model supplies reference and engine strobes.
`timescale 1ns/10ps
module test_uart_baud_fifo_interrupts;
    import ubf_pkg::*;
    localparam int REF_PER = 10;
    localparam logic [15:0] DIV_TAB [6] =
        '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0007, 16'h8002};
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic [2:0]   reg_addr = 3'h0;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic         high_speed = 1'b0;
    logic [4:0]   trig_level = 5'h01;
    logic         stall = 1'b1;
    logic [7:0]   reg_rdata, tx_data, line_ctrl, last_byte;
    logic         ref_osc, rx_push, tx_pop, tx_sh_empty;
    logic         tx_valid, baud_16x, baud_tick, intr;
    ubf_rx_char_s rx_char;
    logic [7:0]   q[$];
    int           error_cnt = 0;
    int           samples_checked = 0;
    int           cyc = 0;

    ubf_uart_core i_dut (
        .SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .REF_OSC(ref_osc),
        .HIGH_SPEED(high_speed), .TRIG_LEVEL(trig_level),
        .RX_PUSH(rx_push), .RX_CHAR(rx_char), .TX_POP(tx_pop),
        .TX_SHIFT_EMPTY(tx_sh_empty), .TX_VALID(tx_valid),
        .TX_DATA(tx_data), .BAUD_16X(baud_16x), .BAUD_TICK(baud_tick),
        .LINE_CTRL(line_ctrl), .INTR(intr)
    );
    ubf_far_model i_far (
        .SYS_CLK(sys_clk), .STALL(stall), .TX_VALID(tx_valid),
        .TX_DATA(tx_data), .REF_OSC(ref_osc), .RX_PUSH(rx_push),
        .RX_CHAR(rx_char), .TX_POP(tx_pop),
        .TX_SHIFT_EMPTY(tx_sh_empty), .LAST_BYTE(last_byte)
    );

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            test_done();
        end
    end
    // ==========================================
    // Tasks and expectations
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] m,
                          input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(16'(reg_rdata & m), 16'(e));
    endtask
    task automatic set_div(input logic [15:0] dv);
        wr(OFS_LCR, 8'h80);
        wr(OFS_DATA, dv[7:0]);
        wr(OFS_IER, dv[15:8]);
        rd_chk(OFS_DATA, 8'hff, dv[7:0]);
        rd_chk(OFS_IER, 8'hff, dv[15:8]);
        chk(16'(line_ctrl), 16'h0080);
        wr(OFS_LCR, 8'h00);
    endtask
    function automatic int eff_div(input logic [15:0] dv, input logic hs);
        int n;
        n = (hs && dv[DIV_HS_BIT]) ? int'(dv[14:0]) : int'(dv);
        return (n == 0) ? 3 : n;
    endfunction
    function automatic int exp_hi(input int n);
        return (n == 1) ? REF_PER / 2 : (n == 2) ? REF_PER : (n - 2) * REF_PER;
    endfunction
    // Clocks between 16x edges, and how many of them were high
    task automatic tick(output int per, output int hi);
        per = 0;
        hi = 0;
        do begin
            @(posedge sys_clk);
            #1 per++;
            hi += int'(baud_16x);
        end while (baud_tick !== 1'b1 && per < 2000);
    endtask
    task automatic measure(input logic [15:0] dv, input logic hs);
        int per, hi;
        high_speed <= hs;
        set_div(dv);
        repeat (4) tick(per, hi);
        chk(16'(per), 16'(eff_div(dv, hs) * REF_PER));
        chk(16'(hi), 16'(exp_hi(eff_div(dv, hs))));
    endtask
    task automatic push(input logic par);
        ubf_rx_char_s c;
        c = {2'b00, par, 8'($urandom)};
        q.push_back(c.data);
        i_far.send(c);
    endtask
    task automatic drain(input int n);
        repeat (n) rd_chk(OFS_DATA, 8'hff, q.pop_front());
    endtask
    // ==========================================
    // Main sequence
    initial begin
        logic [7:0] d;
        void'($urandom(32'hb106ae43));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(OFS_IIR, 8'hff, 8'h01);
        repeat (4) begin
            d = 8'($urandom);
            // Write then read with no gap between the strobes
            @(posedge sys_clk);
            reg_addr <= OFS_SCR;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1 chk(16'(reg_rdata), 16'(d));
            rd_chk(OFS_SCR, 8'hff, d);
            rd_chk(3'h4, 8'hff, 8'h00);
        end
        set_div(16'h0900);
        measure(16'h0003, 1'b0);
        for (int i = 0; i < 6; i++) begin
            measure(DIV_TAB[i], i == 5);
        end
        measure(16'(3 + $urandom % 13), 1'b0);
        set_div(16'h0001);
        wr(OFS_IIR, 8'h01);
        trig_level <= 5'h04;
        wr(OFS_IER, 8'h01);
        for (int i = 0; i < 4; i++) begin
            push(1'b0);
            rd_chk(OFS_IIR, 8'hff, (i == 3) ? 8'hc4 : 8'hc1);
        end
        chk(16'(intr), 16'h0001);
        rd_chk(OFS_LSR, 8'h01, 8'h01);
        drain(1);
        rd_chk(OFS_IIR, 8'hff, 8'hc1);
        drain(3);
        rd_chk(OFS_LSR, 8'h01, 8'h00);
        wr(OFS_IER, 8'h05);
        push(1'b1);
        repeat (3) push(1'b0);
        rd_chk(OFS_IIR, 8'hff, 8'hc6);
        drain(4);
        wr(OFS_IER, 8'h01);
        push(1'b0);
        repeat (3000) @(posedge sys_clk);
        push(1'b0);
        repeat (2500) @(posedge sys_clk);
        rd_chk(OFS_IIR, 8'hff, 8'hc1);
        repeat (2200) @(posedge sys_clk);
        rd_chk(OFS_IIR, 8'hff, 8'hcc);
        drain(1);
        rd_chk(OFS_IIR, 8'hff, 8'hc1);
        repeat (4000) @(posedge sys_clk);
        rd_chk(OFS_IIR, 8'hff, 8'hc1);
        repeat (700) @(posedge sys_clk);
        rd_chk(OFS_IIR, 8'hff, 8'hcc);
        drain(1);
        wr(OFS_IER, 8'h00);
        repeat (4) push(1'b0);
        repeat (4700) @(posedge sys_clk);
        rd_chk(OFS_IIR, 8'hff, 8'hc1);
        rd_chk(OFS_LSR, 8'h01, 8'h01);
        drain(4);
        wr(OFS_IER, 8'h02);
        rd_chk(OFS_IIR, 8'hff, 8'hc2);
        rd_chk(OFS_IIR, 8'hff, 8'hc1);
        d = 8'($urandom);
        wr(OFS_DATA, d);
        repeat (2) @(posedge sys_clk);
        chk(16'(tx_data), 16'(d));
        chk(16'(tx_valid), 16'h0001);
        stall <= 1'b0;
        for (int n = 0; n < 2000 && tx_valid !== 1'b0; n++) begin
            @(posedge sys_clk);
        end
        repeat (300) @(posedge sys_clk);
        chk(16'(last_byte), 16'(d));
        rd_chk(OFS_LSR, 8'h20, 8'h00);
        repeat (1000) @(posedge sys_clk);
        rd_chk(OFS_LSR, 8'h20, 8'h20);
        rd_chk(OFS_IIR, 8'hff, 8'hc2);
        rd_chk(OFS_IIR, 8'hff, 8'hc1);
        stall <= 1'b1;
        wr(OFS_DATA, 8'($urandom));
        wr(OFS_DATA, d);
        stall <= 1'b0;
        for (int n = 0; n < 2000 && tx_valid !== 1'b0; n++) begin
            @(posedge sys_clk);
        end
        repeat (30) @(posedge sys_clk);
        rd_chk(OFS_LSR, 8'h20, 8'h20);
        rd_chk(OFS_IIR, 8'hff, 8'hc2);
        test_done();
    end
endmodule
